// ### verilog/pts_pkg.sv
//------------------------------------------------------------
// What this block does
// - air switch off check overrun: E103 lockout, EA01 warning in alarm mode
// - air switch on check overrun: E104 lockout, EA02 warning in alarm mode
// - prepurge conditions wait overrun: E105 lockout, EA03 warning in alarm mode
// - ignition conditions wait overrun reports E106; absent in regular variant
// - each monitored step times out when idle judgment time passes unadvanced
// - handling setting picks lockout or warning-only with continued operation
// - ignition wait overrun without ignition conditions always locks out
// - low fire stop: firing time after request drop, no low fire: E107
// - all modules stopped, no new request within restart time: E113
// - restart watch runs only in reboot standby or postpurge
// - lockout stays latched until reset input clears it
//------------------------------------------------------------
package pts_pkg;

    // time base
    localparam int unsigned CLK_FREQ_HZ = 50_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ * TICK_S;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IDLE_TIME = 8'h04;
    localparam logic [7:0] OFS_FIRE_TIME = 8'h08;
    localparam logic [7:0] OFS_RESTART_TIME = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_STAT = 8'h14;
    localparam logic [7:0] OFS_INT_MASK = 8'h18;

    // field positions
    localparam int unsigned CTRL_ALARM_MODE = 0;
    localparam int unsigned CTRL_ENABLE = 1;
    localparam int unsigned STAT_LOCKOUT = 0;
    localparam int unsigned STAT_ALARM = 1;
    localparam int unsigned STAT_CODE_LSB = 16;
    localparam int unsigned INT_LOCK = 0;
    localparam int unsigned INT_ALARM = 1;

    // reset values
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [15:0] IDLE_TIME_RST = 16'h003C;
    localparam logic [15:0] FIRE_TIME_RST = 16'h003C;
    localparam logic [15:0] RESTART_TIME_RST = 16'h003C;

    // error and warning codes
    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_E103 = 16'hE103;
    localparam logic [15:0] CODE_E104 = 16'hE104;
    localparam logic [15:0] CODE_E105 = 16'hE105;
    localparam logic [15:0] CODE_E106 = 16'hE106;
    localparam logic [15:0] CODE_E107 = 16'hE107;
    localparam logic [15:0] CODE_E113 = 16'hE113;
    localparam logic [15:0] CODE_EA01 = 16'hEA01;
    localparam logic [15:0] CODE_EA02 = 16'hEA02;
    localparam logic [15:0] CODE_EA03 = 16'hEA03;

    // sequence step reported by the sequencer
    typedef enum logic [2:0] {
        STEP_OTHER = 3'b000,
        STEP_AIR_OFF = 3'b001,
        STEP_AIR_ON = 3'b010,
        STEP_PREPURGE = 3'b011,
        STEP_IGN_WAIT = 3'b100,
        STEP_LOW_FIRE = 3'b101,
        STEP_REBOOT = 3'b110,
        STEP_POSTPURGE = 3'b111
    } pts_step_e;

endpackage

// ### verilog/pts_supervisor.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module pts_supervisor #(
    parameter int unsigned TICK_CYCLES = pts_pkg::TICK_CYCLES,
    parameter bit REGULAR_VARIANT = 1'b0,
    parameter int unsigned TW = 16
) (
    input wire logic MCLK_I, // 50 MHz clock
    input wire logic ARST_N_I, // async reset, active low
    input wire logic CE_I, // clock enable
    input wire logic PSEL_I, // apb select
    input wire logic PENABLE_I, // apb enable
    input wire logic PWRITE_I, // apb write
    input wire logic [7:0] PADDR_I, // apb byte address
    input wire logic [31:0] PWDATA_I, // apb write data
    output logic [31:0] PRDATA_O, // apb read data
    output logic PREADY_O, // apb ready
    output logic PSLVERR_O, // apb error
    input wire logic [2:0] STEP_I, // sequence step code
    input wire logic IGN_COND_I, // ignition conditions present
    input wire logic COMB_REQ_I, // combustion request
    input wire logic LOW_FIRE_I, // low fire position input
    input wire logic ALL_STOP_I, // all control modules stopped
    input wire logic RESET_IN_I, // operator reset input
    output logic LOCKOUT_O, // lockout latched
    output logic ALARM_O, // warning shown
    output logic [15:0] CODE_O, // error or warning code
    output logic IRQ_O // interrupt, level
);

    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else if (CE_I) begin
            sync1_q <= {RESET_IN_I, ALL_STOP_I, LOW_FIRE_I, COMB_REQ_I, IGN_COND_I, STEP_I};
            sync2_q <= sync1_q;
        end
    end

    pts_pkg::pts_step_e step;
    logic ign_cond;
    logic comb_req;
    logic low_fire;
    logic all_stop;
    logic rst_in;

    assign step = pts_pkg::pts_step_e'(sync2_q[2:0]);
    assign ign_cond = sync2_q[3];
    assign comb_req = sync2_q[4];
    assign low_fire = sync2_q[5];
    assign all_stop = sync2_q[6];
    assign rst_in = sync2_q[7];

    logic [2:0] step_prev_q;
    logic rst_prev_q;
    logic chg;
    logic rst_rise;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            step_prev_q <= 3'h0;
            rst_prev_q <= 1'b0;
        end else if (CE_I) begin
            step_prev_q <= step;
            rst_prev_q <= rst_in;
        end
    end

    assign chg = step != step_prev_q;
    assign rst_rise = rst_in && !rst_prev_q;

    //------------------------------------------------------------
    // register file
    //------------------------------------------------------------
    logic [1:0] ctrl_q;
    logic [TW-1:0] idle_time_q;
    logic [TW-1:0] fire_time_q;
    logic [TW-1:0] restart_time_q;
    logic [1:0] int_stat_q;
    logic [1:0] int_mask_q;
    logic lockout_q;
    logic alarm_q;
    logic [15:0] code_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic irq_q;
    logic wr;
    logic setup;
    logic hit;
    logic alarm_mode;
    logic enable;

    assign setup = PSEL_I && !PENABLE_I;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
    assign alarm_mode = ctrl_q[pts_pkg::CTRL_ALARM_MODE];
    assign enable = ctrl_q[pts_pkg::CTRL_ENABLE];

    always_comb begin
        case (PADDR_I)
            pts_pkg::OFS_CTRL, pts_pkg::OFS_IDLE_TIME, pts_pkg::OFS_FIRE_TIME,
            pts_pkg::OFS_RESTART_TIME, pts_pkg::OFS_STATUS, pts_pkg::OFS_INT_STAT,
            pts_pkg::OFS_INT_MASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_q <= pts_pkg::CTRL_RST;
            idle_time_q <= TW'(pts_pkg::IDLE_TIME_RST);
            fire_time_q <= TW'(pts_pkg::FIRE_TIME_RST);
            restart_time_q <= TW'(pts_pkg::RESTART_TIME_RST);
            int_mask_q <= 2'h0;
        end else if (wr) begin
            case (PADDR_I)
                pts_pkg::OFS_CTRL: ctrl_q <= PWDATA_I[1:0];
                pts_pkg::OFS_IDLE_TIME: idle_time_q <= PWDATA_I[TW-1:0];
                pts_pkg::OFS_FIRE_TIME: fire_time_q <= PWDATA_I[TW-1:0];
                pts_pkg::OFS_RESTART_TIME: restart_time_q <= PWDATA_I[TW-1:0];
                pts_pkg::OFS_INT_MASK: int_mask_q <= PWDATA_I[1:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (CE_I && setup) begin
            pslverr_q <= !hit;
            case (PADDR_I)
                pts_pkg::OFS_CTRL: prdata_q <= {30'h0000_0000, ctrl_q};
                pts_pkg::OFS_IDLE_TIME: prdata_q <= 32'(idle_time_q);
                pts_pkg::OFS_FIRE_TIME: prdata_q <= 32'(fire_time_q);
                pts_pkg::OFS_RESTART_TIME: prdata_q <= 32'(restart_time_q);
                pts_pkg::OFS_STATUS: prdata_q <= {code_q, 14'h0000, alarm_q, lockout_q};
                pts_pkg::OFS_INT_STAT: prdata_q <= {30'h0000_0000, int_stat_q};
                pts_pkg::OFS_INT_MASK: prdata_q <= {30'h0000_0000, int_mask_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = pslverr_q && PSEL_I && PENABLE_I;

    //------------------------------------------------------------
    // second tick and timers
    //------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic tick;
    logic [TW-1:0] step_tmr_q;
    logic [TW-1:0] lf_tmr_q;
    logic [TW-1:0] rs_tmr_q;
    logic lf_run;
    logic rs_run;

    assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);
    assign lf_run = step == pts_pkg::STEP_LOW_FIRE && !comb_req && !chg;
    assign rs_run = (step == pts_pkg::STEP_REBOOT || step == pts_pkg::STEP_POSTPURGE)
        && all_stop && !comb_req && !chg;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tick_cnt_q <= 32'h0000_0000;
        end else if (CE_I) begin
            tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            step_tmr_q <= '0;
        end else if (CE_I) begin
            if (chg) begin
                step_tmr_q <= '0;
            end else if (tick && step_tmr_q != '1) begin
                step_tmr_q <= step_tmr_q + TW'(1);
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lf_tmr_q <= '0;
            rs_tmr_q <= '0;
        end else if (CE_I) begin
            if (!lf_run) begin
                lf_tmr_q <= '0;
            end else if (tick && lf_tmr_q != '1) begin
                lf_tmr_q <= lf_tmr_q + TW'(1);
            end
            if (!rs_run) begin
                rs_tmr_q <= '0;
            end else if (tick && rs_tmr_q != '1) begin
                rs_tmr_q <= rs_tmr_q + TW'(1);
            end
        end
    end

    //------------------------------------------------------------
    // timeout judgment
    //------------------------------------------------------------
    logic fired_q;
    logic idle_mon;
    logic idle_to;
    logic lf_to;
    logic rs_to;
    logic lock_ev;
    logic alarm_ev;
    logic [15:0] ev_code;

    assign idle_mon = step == pts_pkg::STEP_AIR_OFF || step == pts_pkg::STEP_AIR_ON
        || step == pts_pkg::STEP_PREPURGE
        || (step == pts_pkg::STEP_IGN_WAIT && !REGULAR_VARIANT);
    assign idle_to = enable && !fired_q && !chg && idle_mon && step_tmr_q >= idle_time_q;
    assign lf_to = enable && !fired_q && lf_run && !low_fire && lf_tmr_q >= fire_time_q;
    assign rs_to = enable && !fired_q && rs_run && rs_tmr_q >= restart_time_q;

    always_comb begin
        lock_ev = 1'b0;
        alarm_ev = 1'b0;
        ev_code = pts_pkg::CODE_NONE;
        if (idle_to) begin
            case (step)
                pts_pkg::STEP_AIR_OFF: ev_code = alarm_mode ? pts_pkg::CODE_EA01 : pts_pkg::CODE_E103;
                pts_pkg::STEP_AIR_ON: ev_code = alarm_mode ? pts_pkg::CODE_EA02 : pts_pkg::CODE_E104;
                pts_pkg::STEP_PREPURGE: ev_code = alarm_mode ? pts_pkg::CODE_EA03 : pts_pkg::CODE_E105;
                default: ev_code = pts_pkg::CODE_E106;
            endcase
            if (step == pts_pkg::STEP_IGN_WAIT && !ign_cond) begin
                lock_ev = 1'b1;
            end else begin
                lock_ev = !alarm_mode;
                alarm_ev = alarm_mode;
            end
        end else if (lf_to) begin
            lock_ev = 1'b1;
            ev_code = pts_pkg::CODE_E107;
        end else if (rs_to) begin
            lock_ev = 1'b1;
            ev_code = pts_pkg::CODE_E113;
        end
    end

    // one judgment per step visit
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fired_q <= 1'b0;
        end else if (CE_I) begin
            if (chg) begin
                fired_q <= 1'b0;
            end else if (lock_ev || alarm_ev) begin
                fired_q <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // lockout, warning and interrupt
    //------------------------------------------------------------
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lockout_q <= 1'b0;
            alarm_q <= 1'b0;
            code_q <= pts_pkg::CODE_NONE;
        end else if (CE_I) begin
            if (lock_ev) begin
                lockout_q <= 1'b1;
                alarm_q <= 1'b0;
                if (!lockout_q) begin
                    code_q <= ev_code;
                end
            end else if (lockout_q) begin
                if (rst_rise) begin
                    lockout_q <= 1'b0;
                    code_q <= pts_pkg::CODE_NONE;
                end
            end else if (alarm_ev) begin
                alarm_q <= 1'b1;
                code_q <= ev_code;
            end else if (alarm_q && (chg || rst_rise)) begin
                alarm_q <= 1'b0;
                code_q <= pts_pkg::CODE_NONE;
            end
        end
    end

    // sticky events, set wins over write-one-clear
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            int_stat_q <= 2'h0;
            irq_q <= 1'b0;
        end else if (CE_I) begin
            int_stat_q <= (int_stat_q & ~((wr && PADDR_I == pts_pkg::OFS_INT_STAT) ? PWDATA_I[1:0] : 2'h0))
                | {alarm_ev, lock_ev};
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    assign LOCKOUT_O = lockout_q;
    assign ALARM_O = alarm_q;
    assign CODE_O = code_q;
    assign IRQ_O = irq_q;

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);

    a_air_off_code: assert property (CE_I && idle_to && step == pts_pkg::STEP_AIR_OFF && !lockout_q
        |=> code_q == ($past(alarm_mode) ? pts_pkg::CODE_EA01 : pts_pkg::CODE_E103))
        else $error("air switch off timeout code wrong");

    a_air_on_code: assert property (CE_I && idle_to && step == pts_pkg::STEP_AIR_ON && !lockout_q
        |=> code_q == ($past(alarm_mode) ? pts_pkg::CODE_EA02 : pts_pkg::CODE_E104))
        else $error("air switch on timeout code wrong");

    a_prepurge_code: assert property (CE_I && idle_to && step == pts_pkg::STEP_PREPURGE && !lockout_q
        |=> code_q == ($past(alarm_mode) ? pts_pkg::CODE_EA03 : pts_pkg::CODE_E105))
        else $error("prepurge wait timeout code wrong");

    a_ign_variant: assert property (CE_I && idle_to && step == pts_pkg::STEP_IGN_WAIT && !lockout_q
        |=> !REGULAR_VARIANT && code_q == pts_pkg::CODE_E106)
        else $error("ignition wait code wrong for variant");

    a_timeout_time: assert property (idle_to |-> step_tmr_q >= idle_time_q && step == $past(step))
        else $error("timeout before judgment time");

    a_alarm_only: assert property (CE_I && alarm_ev && !lockout_q |=> alarm_q && !lockout_q)
        else $error("alarm mode changed operation");

    a_ign_lock: assert property (CE_I && idle_to && step == pts_pkg::STEP_IGN_WAIT && !ign_cond
        |=> lockout_q)
        else $error("ignition wait without conditions did not lock");

    a_low_fire: assert property (CE_I && lf_to && !idle_to && !lockout_q
        |=> lockout_q && code_q == pts_pkg::CODE_E107)
        else $error("low fire stop lockout missing");

    a_restart_lock: assert property (CE_I && rs_to && !lf_to && !idle_to && !lockout_q
        |=> lockout_q && code_q == pts_pkg::CODE_E113)
        else $error("restart timeout lockout missing");

    a_restart_scope: assert property (rs_tmr_q != '0
        |-> step_prev_q == pts_pkg::STEP_REBOOT || step_prev_q == pts_pkg::STEP_POSTPURGE)
        else $error("restart timer ran outside its steps");

    a_lock_hold: assert property (lockout_q && !(CE_I && rst_rise) |=> lockout_q)
        else $error("lockout dropped without reset input");

    a_lock_clear: assert property (lockout_q && CE_I && rst_rise && !lock_ev |=> !lockout_q)
        else $error("reset input did not clear lockout");

    a_tmr_entry: assert property (CE_I && chg |=> step_tmr_q == '0)
        else $error("step timer not restarted on entry");

    c_air_off_lock: cover property (lock_ev && ev_code == pts_pkg::CODE_E103);
    c_alarm_warn: cover property (alarm_ev ##1 alarm_q);
    c_low_fire: cover property (lf_to);
    c_restart: cover property (rs_to);
    c_reset_clear: cover property (lockout_q ##1 !lockout_q);

endmodule // pts_supervisor

// ### tb/pts_plant.sv
`timescale 1ns/10ps
module pts_plant (
    input wire logic clk_i, // bench clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [2:0] step_cmd_i, // step the sequencer is in
    input wire logic [3:0] cond_cmd_i, // ignition, request, low fire, all stopped
    input wire logic reset_req_i, // operator presses reset, one cycle
    output logic [2:0] step_o, // sequence step pin
    output logic ign_o, // ignition conditions present
    output logic comb_o, // combustion request
    output logic low_fire_o, // low fire position reached
    output logic all_stop_o, // all control modules stopped
    output logic reset_o // operator reset input
);
    logic [2:0] press_q;

    //------------------------------------------------------------
    // pins follow the plant one cycle after a command
    //------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_o <= 3'h0;
            {ign_o, comb_o, low_fire_o, all_stop_o} <= 4'h0;
        end else begin
            step_o <= step_cmd_i;
            {ign_o, comb_o, low_fire_o, all_stop_o} <= cond_cmd_i;
        end
    end

    //------------------------------------------------------------
    // operator reset held high for four cycles after a one-cycle request
    //------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            press_q <= 3'h0;
        end else if (reset_req_i) begin
            press_q <= 3'h4;
        end else if (press_q != 3'h0) begin
            press_q <= press_q - 3'h1;
        end
    end

    assign reset_o = (press_q != 3'h0);
endmodule // pts_plant

// ### tb/process_timeout_supervisor_test.sv
`timescale 1ns/10ps
module process_timeout_supervisor_test;
    typedef struct {
        logic [2:0] step;
        logic [4:0] in_b; // alarm mode, ignition, request, low fire, all stopped
        logic [1:0] out_b; // lockout, alarm
        logic [15:0] code;
    } pts_row_s;

    logic clk, rst_n, psel, penable, pwrite, rreq, err;
    logic pready, pslverr, lockout, alarm, irq, ign, comb, lowf, stop, rst_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] step_c, step;
    logic [3:0] cond_c;
    logic [15:0] code;
    int err_count = 0;
    int checked = 0;
    pts_row_s rows [17] = '{
        '{3'h1, 5'h00, 2'h2, 16'hE103}, '{3'h1, 5'h10, 2'h1, 16'hEA01},
        '{3'h2, 5'h00, 2'h2, 16'hE104}, '{3'h2, 5'h10, 2'h1, 16'hEA02},
        '{3'h3, 5'h00, 2'h2, 16'hE105}, '{3'h3, 5'h10, 2'h1, 16'hEA03},
        '{3'h4, 5'h08, 2'h2, 16'hE106}, '{3'h4, 5'h10, 2'h2, 16'hE106},
        '{3'h4, 5'h18, 2'h1, 16'hE106}, '{3'h5, 5'h00, 2'h2, 16'hE107},
        '{3'h6, 5'h01, 2'h2, 16'hE113}, '{3'h7, 5'h01, 2'h2, 16'hE113},
        '{3'h0, 5'h01, 2'h0, 16'h0000}, '{3'h5, 5'h04, 2'h0, 16'h0000},
        '{3'h5, 5'h02, 2'h0, 16'h0000}, '{3'h6, 5'h00, 2'h0, 16'h0000},
        '{3'h7, 5'h05, 2'h0, 16'h0000}};

    pts_supervisor #(.TICK_CYCLES(10)) i_dut (.MCLK_I(clk), .ARST_N_I(rst_n), .CE_I(1'h1), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .STEP_I(step), .IGN_COND_I(ign), .COMB_REQ_I(comb),
        .LOW_FIRE_I(lowf), .ALL_STOP_I(stop), .RESET_IN_I(rst_in), .LOCKOUT_O(lockout), .ALARM_O(alarm),
        .CODE_O(code), .IRQ_O(irq));
    pts_plant i_plant (.clk_i(clk), .rst_n_i(rst_n), .step_cmd_i(step_c), .cond_cmd_i(cond_c),
        .reset_req_i(rreq), .step_o(step), .ign_o(ign), .comb_o(comb), .low_fire_o(lowf),
        .all_stop_o(stop), .reset_o(rst_in));

    //------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------
    task automatic end_sim;
        if (err_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            chk(32'h0, 32'h1);
            end_sim();
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic press_reset;
        @(posedge clk);
        rreq <= 1'h1;
        @(posedge clk);
        rreq <= 1'h0;
        repeat (12) @(posedge clk);
        #1;
    endtask

    task automatic run_row(input pts_row_s r, input logic exp_irq);
        int n;
        apb(1'h1, pts_pkg::OFS_CTRL, {30'h0, 1'h1, r.in_b[4]});
        @(posedge clk);
        cond_c <= r.in_b[3:0];
        step_c <= r.step;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (lockout !== 1'h1 && alarm !== 1'h1 && n < 100);
        if (r.out_b === 2'h0) begin
            chk({lockout, alarm, code}, 18'h0);
        end else begin
            if (n >= 100) begin
                chk(32'h0, 32'h1);
                end_sim();
            end
            chk(n >= 16 && n <= 25, 1'h1);
            chk({lockout, alarm, code}, {r.out_b, r.code});
            repeat (3) @(posedge clk);
            #1;
            chk(irq, exp_irq);
            rdchk(pts_pkg::OFS_STATUS, {r.code, 14'h0, r.out_b[0], r.out_b[1]});
        end
        @(posedge clk);
        step_c <= 3'h0;
        cond_c <= 4'h0;
        repeat (40) @(posedge clk);
        #1;
        chk({lockout, alarm}, {r.out_b[1], 1'h0});
        press_reset();
        chk({lockout, code}, 17'h0);
        apb(1'h1, pts_pkg::OFS_INT_STAT, 32'h0000_0003);
        repeat (3) @(posedge clk);
        #1;
        chk(irq, 1'h0);
    endtask

    //------------------------------------------------------------
    // clock, watchdog, main sequence
    //------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        chk(32'h0, 32'h1);
        end_sim();
    end

    initial begin
        {rst_n, psel, penable, pwrite, rreq} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        step_c = 3'h0;
        cond_c = 4'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        #1;
        chk({lockout, alarm, code, irq, pready}, 20'h0_0001);
        rdchk(pts_pkg::OFS_CTRL, 32'h0000_0002);
        rdchk(pts_pkg::OFS_IDLE_TIME, 32'h0000_003C);
        rdchk(pts_pkg::OFS_FIRE_TIME, 32'h0000_003C);
        rdchk(pts_pkg::OFS_RESTART_TIME, 32'h0000_003C);
        rdchk(pts_pkg::OFS_INT_MASK, 32'h0000_0000);
        apb(1'h1, pts_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        rdchk(pts_pkg::OFS_STATUS, 32'h0000_0000);
        rdchk(8'h1C, 32'h0000_0000);
        chk(err, 1'h1);
        apb(1'h1, pts_pkg::OFS_IDLE_TIME, 32'h0000_0002);
        apb(1'h1, pts_pkg::OFS_FIRE_TIME, 32'h0000_0002);
        apb(1'h1, pts_pkg::OFS_RESTART_TIME, 32'h0000_0002);
        apb(1'h1, pts_pkg::OFS_INT_MASK, 32'h0000_0003);
        foreach (rows[i]) run_row(rows[i], 1'h1);
        // masked warning must not interrupt
        apb(1'h1, pts_pkg::OFS_INT_MASK, 32'h0000_0001);
        run_row('{3'h1, 5'h10, 2'h1, 16'hEA01}, 1'h0);
        // step changes inside the judgment time never time out
        apb(1'h1, pts_pkg::OFS_IDLE_TIME, 32'h0000_0004);
        apb(1'h1, pts_pkg::OFS_CTRL, 32'h0000_0002);
        @(posedge clk);
        step_c <= 3'h1;
        repeat (8) begin
            repeat (15) @(posedge clk);
            step_c <= (step_c === 3'h1) ? 3'h2 : 3'h1;
        end
        #1;
        chk(lockout, 1'h0);
        repeat (60) @(posedge clk);
        #1;
        chk({lockout, code}, {1'h1, 16'hE103});
        @(posedge clk);
        step_c <= 3'h0;
        press_reset();
        chk(lockout, 1'h0);
        // judgments off while the enable bit is clear
        apb(1'h1, pts_pkg::OFS_CTRL, 32'h0000_0000);
        @(posedge clk);
        step_c <= 3'h1;
        repeat (80) @(posedge clk);
        #1;
        chk({lockout, alarm, code}, 18'h0);
        // reset in mid-run restores defaults
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        #1;
        chk({lockout, alarm, code, irq}, 19'h0);
        rdchk(pts_pkg::OFS_CTRL, 32'h0000_0002);
        rdchk(pts_pkg::OFS_IDLE_TIME, 32'h0000_003C);
        end_sim();
    end
endmodule // process_timeout_supervisor_test
